// ### src/rsd_pkg.sv
// constants of the row scan display control block
package rsd_pkg;
	// command register indices
	localparam logic [7:0] IDX_ACTIVE_ROW_COUNT = 8'h02;
	localparam logic [7:0] IDX_SCAN_DIRECTION_CONTROL = 8'h03;
	localparam logic [7:0] IDX_FIRST_SCAN_ROW = 8'h30;
	localparam logic [7:0] IDX_VERTICAL_SCROLL_LINES = 8'h31;
	localparam logic [7:0] IDX_DISPLAY_FIRST_LINE = 8'h32;
	localparam logic [7:0] IDX_DISPLAY_LAST_LINE = 8'h33;

	// field positions inside scan_direction_control
	localparam int POS_COL_DIR = 0;
	localparam int POS_GATE_DIR = 1;
	localparam int POS_PAIR_ILV = 2;

	// values after reset
	localparam logic [5:0] RST_ACTIVE_ROW_COUNT = 6'h3f;
	localparam logic [2:0] RST_SCAN_DIRECTION = 3'h0;
	localparam logic [5:0] RST_SCAN_START_ROW = 6'h00;
	localparam logic [5:0] RST_VERTICAL_SCROLL = 6'h00;
	localparam logic [5:0] RST_DISPLAY_START = 6'h00;
	localparam logic [5:0] RST_DISPLAY_END = 6'h3f;

	// geometry
	localparam int ROW_W = 6;
	localparam int NUM_ROWS = 64;
	localparam int NUM_COLS = 128;
	localparam logic [5:0] LAST_ROW = 6'h3f;

	// row dwell time and its count of mclk cycles at 10 MHz
	localparam int CLK_PERIOD_NS = 100;
	localparam int ROW_TIME_NS = 1600;
	localparam int ROW_CYCLES = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] ROW_LAST_CYC = 8'(ROW_CYCLES - 1);

	typedef enum logic [1:0] {
		RSD_SEQ_ASC,
		RSD_SEQ_DESC,
		RSD_PAIR_ASC,
		RSD_PAIR_DESC
	} rsd_order_t;
endpackage : rsd_pkg

// ### src/rsd_scan_ctrl.sv
// row scan order, line mapping and column direction of the display driver
// How it works
// [R01] pair select 0, direction 0: rows scanned 0 up to 63
// [R02] pair select 0, direction 1: rows scanned 63 down to 0
// [R03] pair select 1, direction 0: pairs ascending, odd row first
// [R04] both selects 1: pairs descending, even row first
// [R05] index 02h holds six-bit active row count, reset 3Fh
// [R06] index 03h: pair select bit2, gate dir bit1, column dir bit0
// [R07] column dir 0 maps C0..C127 ascending, 1 reverses them
// [R08] index 30h holds six-bit first scanned row, reset zero
// [R09] index 31h holds six-bit scroll, image moves up that many rows
// [R10] indices 32h/33h hold start/end line; only scan steps between shown
// [R11] pair select 0: first row is the value, or 63 minus it when direction is 1
// [R12] start display line shifts by exactly the scroll value, 0..63
// [R13] count plus one rows driven per frame; others stay inactive
// [R14] row and line arithmetic wraps modulo 64
`timescale 1ns/1ps
module rsd_scan_ctrl (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_index,
	input wire logic [7:0] cmd_data,
	input wire logic [127:0] line_pixels,
	output logic [63:0] row_drive_q,
	output logic [127:0] col_drive_q,
	output logic [5:0] line_addr_q,
	output logic line_visible_q,
	output logic [5:0] scan_row_q,
	output logic [5:0] scan_step_q,
	output logic row_start_q,
	output logic frame_start_q
);
	// command registers
	logic [5:0] row_count_q;
	logic [2:0] scan_dir_q;
	logic [5:0] first_row_q;
	logic [5:0] scroll_q;
	logic [5:0] first_line_q;
	logic [5:0] last_line_q;

	// row timing and next-row values
	logic [7:0] cyc_q;
	logic [7:0] cyc_d;
	logic [5:0] step_d;
	logic [5:0] row_d;
	logic [5:0] line_d;
	logic vis_d;
	logic [127:0] col_d;
	logic started_q;

	// write strobe aimed at one command index
	function automatic logic hit(input logic wr, input logic [7:0] idx,
			input logic [7:0] want);
		return wr && (idx == want);
	endfunction : hit

	wire row_tick = (cyc_q == rsd_pkg::ROW_LAST_CYC);
	wire pair_sel = scan_dir_q[rsd_pkg::POS_PAIR_ILV];
	wire gate_rev = scan_dir_q[rsd_pkg::POS_GATE_DIR];
	wire col_rev = scan_dir_q[rsd_pkg::POS_COL_DIR];
	rsd_pkg::rsd_order_t order;
	assign order = rsd_pkg::rsd_order_t'({pair_sel, gate_rev});

	wire wr_count = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_ACTIVE_ROW_COUNT);
	wire wr_dir = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_SCAN_DIRECTION_CONTROL);
	wire wr_first_row = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_FIRST_SCAN_ROW);
	wire wr_scroll = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_VERTICAL_SCROLL_LINES);
	wire wr_first_line = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_DISPLAY_FIRST_LINE);
	wire wr_last_line = hit(cmd_wr, cmd_index,
		rsd_pkg::IDX_DISPLAY_LAST_LINE);
	// any other index is dropped silently; there is no readback
	wire wr_any = wr_count || wr_dir || wr_first_row || wr_scroll
		|| wr_first_line || wr_last_line;

	// physical gate row for a scan step; 6-bit sums wrap by themselves
	function automatic logic [5:0] row_of(input rsd_pkg::rsd_order_t ord,
			input logic [5:0] start, input logic [5:0] step);
		logic [5:0] base;
		base = 6'h00;
		unique case (ord)
			rsd_pkg::RSD_SEQ_ASC: base = start + step; // R01 R14
			rsd_pkg::RSD_SEQ_DESC: base = (rsd_pkg::LAST_ROW - start) - step; // R02 R11
			rsd_pkg::RSD_PAIR_ASC: base = (start + step) ^ 6'h01; // R03
			rsd_pkg::RSD_PAIR_DESC: base = ((rsd_pkg::LAST_ROW - start) - step) ^ 6'h01; // R04
		endcase
		return base;
	endfunction : row_of

	function automatic logic [127:0] rev_cols(input logic [127:0] v);
		logic [127:0] r;
		r = 128'h0;
		for (int i = 0; i < rsd_pkg::NUM_COLS; i++) begin
			r[i] = v[rsd_pkg::NUM_COLS - 1 - i];
		end
		return r;
	endfunction : rev_cols

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			row_count_q <= rsd_pkg::RST_ACTIVE_ROW_COUNT;
			scan_dir_q <= rsd_pkg::RST_SCAN_DIRECTION;
			first_row_q <= rsd_pkg::RST_SCAN_START_ROW;
			scroll_q <= rsd_pkg::RST_VERTICAL_SCROLL;
			first_line_q <= rsd_pkg::RST_DISPLAY_START;
			last_line_q <= rsd_pkg::RST_DISPLAY_END;
		end else begin
			if (wr_count) row_count_q <= cmd_data[5:0]; // R05
			if (wr_dir) scan_dir_q <= cmd_data[2:0]; // R06
			if (wr_first_row) first_row_q <= cmd_data[5:0]; // R08
			if (wr_scroll) scroll_q <= cmd_data[5:0]; // R09
			if (wr_first_line) first_line_q <= cmd_data[5:0]; // R10
			if (wr_last_line) last_line_q <= cmd_data[5:0]; // R10
		end
	end

	// first tick starts step 0; a shrunk count takes effect at once
	assign cyc_d = row_tick ? 8'h00 : cyc_q + 8'h01;
	assign step_d = (!started_q || scan_step_q >= row_count_q) ? 6'h00 :
		scan_step_q + 6'h01; // R13
	assign row_d = row_of(order, first_row_q, step_d); // R11
	assign line_d = step_d + scroll_q; // R09 R12 R14
	// window is held against the scan step, not the scrolled line
	assign vis_d = (step_d >= first_line_q) && (step_d <= last_line_q); // R10
	// blanked lines drive no column current
	assign col_d = !line_visible_q ? 128'h0 :
		col_rev ? rev_cols(line_pixels) : line_pixels; // R07

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_q <= 8'h00;
			started_q <= 1'b0;
			scan_step_q <= 6'h00;
			scan_row_q <= 6'h00;
			line_addr_q <= 6'h00;
			line_visible_q <= 1'b0;
			row_drive_q <= 64'h0;
			row_start_q <= 1'b0;
			frame_start_q <= 1'b0;
		end else begin
			cyc_q <= cyc_d;
			row_start_q <= row_tick;
			frame_start_q <= row_tick && (step_d == 6'h00);
			if (row_tick) begin
				started_q <= 1'b1;
				scan_step_q <= step_d;
				scan_row_q <= row_d;
				line_addr_q <= line_d;
				line_visible_q <= vis_d;
				// one gate active at a time, the rest left inactive
				row_drive_q <= 64'h1 << row_d; // R13
			end
		end
	end

	// pixels for line_addr_q come back combinationally from the frame store
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			col_drive_q <= 128'h0;
		end else begin
			col_drive_q <= col_d;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_tick_seq_asc;
		row_tick && !pair_sel && !gate_rev;
	endsequence
	sequence s_tick_pair;
		row_tick && pair_sel;
	endsequence
	sequence s_frame_begin;
		row_tick && (step_d == 6'h00);
	endsequence
	sequence s_quiet_write;
		cmd_wr && !wr_any;
	endsequence

	a_asc_order: assert property (s_tick_seq_asc |=> // R01
		scan_row_q == 6'($past(first_row_q) + scan_step_q))
		else $error("ascending scan row wrong");

	a_desc_order: assert property (row_tick && !pair_sel && gate_rev |=> // R02
		scan_row_q == 6'(rsd_pkg::LAST_ROW - $past(first_row_q)
		- scan_step_q))
		else $error("descending scan row wrong");

	a_pair_asc: assert property (s_tick_pair ##0 !gate_rev |=> // R03
		scan_row_q == (6'($past(first_row_q) + scan_step_q) ^ 6'h01))
		else $error("pair ascending row wrong");

	a_pair_desc: assert property (s_tick_pair ##0 gate_rev |=> // R04
		scan_row_q == (6'(rsd_pkg::LAST_ROW - $past(first_row_q)
		- scan_step_q) ^ 6'h01))
		else $error("pair descending row wrong");

	a_first_asc: assert property (s_frame_begin ##0 !gate_rev // R11
		##0 !pair_sel |=> scan_row_q == $past(first_row_q))
		else $error("first row not the start value");

	a_first_desc: assert property (s_frame_begin ##0 gate_rev // R11
		##0 !pair_sel |=>
		scan_row_q == 6'(rsd_pkg::LAST_ROW - $past(first_row_q)))
		else $error("first row not mirrored start value");

	a_reset_defaults: assert property ($rose(rst_n) |-> // R05 R06 R10
		row_count_q == 6'h3f && scan_dir_q == 3'h0
		&& first_line_q == 6'h00 && last_line_q == 6'h3f
		&& first_row_q == 6'h00 && scroll_q == 6'h00)
		else $error("register reset value wrong");

	a_cmd_write: assert property (wr_count ##1 !wr_count [*2] |-> // R05
		row_count_q == $past(cmd_data[5:0], 2))
		else $error("active row count not stored");

	a_dir_write: assert property (wr_dir |=> // R06
		scan_dir_q == $past(cmd_data[2:0]))
		else $error("scan direction not stored");

	a_start_write: assert property (wr_first_row |=> // R08
		first_row_q == $past(cmd_data[5:0]))
		else $error("first scan row not stored");

	a_scroll_write: assert property (wr_scroll |=> // R09
		scroll_q == $past(cmd_data[5:0]))
		else $error("scroll value not stored");

	a_window_write: assert property (wr_first_line |=> // R10
		first_line_q == $past(cmd_data[5:0]))
		else $error("start line not stored");

	a_window_end: assert property (wr_last_line |=> // R10
		last_line_q == $past(cmd_data[5:0]))
		else $error("end line not stored");

	a_other_index: assert property (s_quiet_write |=> // R05 R06
		$stable(row_count_q) && $stable(scan_dir_q)
		&& $stable(first_row_q) && $stable(scroll_q)
		&& $stable(first_line_q) && $stable(last_line_q))
		else $error("unknown index changed a register");

	a_col_dir: assert property (line_visible_q && !wr_dir |=> // R07
		col_drive_q == ($past(col_rev) ? rev_cols($past(line_pixels))
		: $past(line_pixels)))
		else $error("column mapping wrong");

	a_hidden_blank: assert property (!line_visible_q |=> // R10
		col_drive_q == 128'h0)
		else $error("hidden line drives columns");

	a_scroll_line: assert property (row_tick |=> // R09 R12 R14
		line_addr_q == 6'(scan_step_q + $past(scroll_q)))
		else $error("scrolled line address wrong");

	a_frame_line: assert property (frame_start_q |-> // R12
		line_addr_q == $past(scroll_q))
		else $error("frame start line not shifted by scroll");

	a_line_window: assert property (row_tick |=> // R10
		line_visible_q == (scan_step_q >= $past(first_line_q)
		&& scan_step_q <= $past(last_line_q)))
		else $error("visible line window wrong");

	a_frame_wrap: assert property (row_tick && started_q // R13
		&& scan_step_q >= row_count_q |=>
		scan_step_q == 6'h00 && frame_start_q)
		else $error("frame did not wrap after last active row");

	a_step_advance: assert property (row_tick && started_q // R13
		&& scan_step_q < row_count_q |=>
		scan_step_q == 6'($past(scan_step_q) + 6'h01))
		else $error("scan step did not advance");

	a_one_gate: assert property (row_start_q |-> // R13
		$onehot(row_drive_q) && row_drive_q[scan_row_q])
		else $error("gate drive not one-hot");

	a_idle_gates: assert property (!started_q |-> // R13
		row_drive_q == 64'h0)
		else $error("gate driven before first row");

	a_row_steady: assert property (!row_tick |=> // R13
		$stable(scan_row_q) && $stable(row_drive_q))
		else $error("gate row changed inside a row time");

	a_pulse_once: assert property (row_start_q |=> // R13
		!row_start_q)
		else $error("row pulse longer than one cycle");

	a_frame_pulse: assert property (frame_start_q |-> // R13
		row_start_q && scan_step_q == 6'h00)
		else $error("frame pulse outside step zero");
endmodule : rsd_scan_ctrl

// ### verification/rsd_panel_model.sv
// panel side model: frame store row fetched by display line
`timescale 1ns/1ps
module rsd_panel_model (
	input wire logic [5:0] line_addr,
	output logic [127:0] line_pixels
);
	// each stored row holds its own line number so a wrong fetch shows
	assign line_pixels = {122'h0, line_addr};
endmodule : rsd_panel_model

// ### verification/tb.sv
// self-checking bench of the row scan display control
`timescale 1ns/1ps
module tb;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] scan_start_row;
		logic [5:0] r0;
		logic [5:0] r1;
	} rsd_case_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cmd_wr = 1'b0;
	logic [7:0] cmd_index = 8'h00;
	logic [7:0] cmd_data = 8'h00;
	wire [127:0] line_pixels;
	wire [63:0] row_drive_q;
	wire [127:0] col_drive_q;
	wire [5:0] line_addr_q;
	wire line_visible_q;
	wire [5:0] scan_row_q;
	wire [5:0] scan_step_q;
	wire row_start_q;
	wire frame_start_q;
	int err_total = 0;
	int n_compared = 0;
	int i;
	rsd_case_t cases [6] = '{'{8'h00, 8'h00, 6'h00, 6'h01},
		'{8'h02, 8'h00, 6'h3f, 6'h3e}, '{8'h04, 8'h00, 6'h01, 6'h00},
		'{8'h06, 8'h00, 6'h3e, 6'h3f}, '{8'h02, 8'h20, 6'h1f, 6'h1e},
		'{8'hf8, 8'hff, 6'h3f, 6'h00}};
	always #50 mclk = ~mclk;
	rsd_scan_ctrl rsd_scan_ctrl_i (.mclk(mclk), .rst_n(rst_n),
		.cmd_wr(cmd_wr), .cmd_index(cmd_index), .cmd_data(cmd_data),
		.line_pixels(line_pixels), .row_drive_q(row_drive_q),
		.col_drive_q(col_drive_q), .line_addr_q(line_addr_q),
		.line_visible_q(line_visible_q), .scan_row_q(scan_row_q),
		.scan_step_q(scan_step_q), .row_start_q(row_start_q),
		.frame_start_q(frame_start_q));
	rsd_panel_model rsd_panel_model_i (.line_addr(line_addr_q),
		.line_pixels(line_pixels));
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string name, input logic [127:0] seen,
		input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [7:0] data);
		@(posedge mclk);
		#1 cmd_wr = 1'b1;
		cmd_index = idx;
		cmd_data = data;
		@(posedge mclk);
		#1 cmd_wr = 1'b0;
	endtask : wr
	// frame pulse when on, otherwise row pulse; bounded so a stall ends
	task automatic wait_for(input bit frame);
		for (int n = 0; n < 2000; n++) begin
			@(posedge mclk);
			#1;
			if ((frame ? frame_start_q : row_start_q) === 1'b1) return;
		end
		$display("ERROR pulse wait ran out");
		err_total++;
		finish_test();
	endtask : wait_for
	initial begin
		repeat (12) @(posedge mclk);
		#1 rst_n = 1'b1;
		chk("idle_rows", row_drive_q, 0);
		wait_for(1);
		chk("first_row", scan_row_q, 0);
		chk("first_line", line_addr_q, 0);
		chk("visible", line_visible_q, 1);
		for (i = 0; i < 63; i++) wait_for(0);
		chk("last_step", scan_step_q, 6'h3f);
		$display("reset defaults done");
		wr(8'h02, 8'hc3);
		foreach (cases[k]) begin
			wr(8'h03, cases[k].ctrl);
			wr(8'h30, cases[k].scan_start_row);
			wr(8'h34, 8'hff);
			wait_for(1);
			chk("row0", scan_row_q, cases[k].r0);
			chk("onehot", row_drive_q, 64'h1 << cases[k].r0);
			wait_for(0);
			chk("row1", scan_row_q, cases[k].r1);
		end
		$display("scan orders done");
		wr(8'h03, 8'h01);
		wr(8'h31, 8'h10);
		wait_for(1);
		chk("scroll", line_addr_q, 6'h10);
		// column data trails the line address by one cycle
		@(posedge mclk);
		#1 chk("reversed", col_drive_q, {<<{128'h10}});
		wr(8'h03, 8'h00);
		wr(8'h31, 8'h3f);
		wait_for(1);
		@(posedge mclk);
		#1 chk("ascending", col_drive_q, 128'h3f);
		wait_for(0);
		chk("wrap_line", line_addr_q, 6'h00);
		$display("scroll and columns done");
		wr(8'h32, 8'h01);
		wr(8'h33, 8'h02);
		wait_for(1);
		chk("hidden", line_visible_q, 0);
		@(posedge mclk);
		#1 chk("blank", col_drive_q, 0);
		for (i = 1; i < 70; i++) begin
			wait_for(0);
			if (i == 1) chk("shown", line_visible_q, 1);
			if (frame_start_q === 1'b1) break;
		end
		chk("rows_per_frame", i, 4);
		$display("window and count done");
		@(posedge mclk);
		#1 rst_n = 1'b0;
		#1 chk("reset_rows", row_drive_q, 0);
		@(posedge mclk);
		#1 rst_n = 1'b1;
		wait_for(1);
		chk("reset_row", scan_row_q, 0);
		chk("reset_line", line_addr_q, 0);
		$display("second reset done");
		finish_test();
	end
endmodule : tb
